/* File: esm_top.sv */
`timescale 1ns/10ps
`include "esm_consts.svh"

module esm_top
    import esm_pkg::*;
(
    input  wire logic        REF_CLK_IN,           // bus clock, 250 MHz
    input  wire logic        RST_IN,               // async reset, active high
    input  wire logic        PSEL_IN,              // apb select
    input  wire logic        PENABLE_IN,           // apb enable
    input  wire logic        PWRITE_IN,            // apb direction
    input  wire logic [7:0]  PADDR_IN,             // apb byte address
    input  wire logic [31:0] PWDATA_IN,            // apb write data
    output logic      [31:0] PRDATA_OUT,           // apb read data
    output logic             PREADY_OUT,           // apb ready
    output logic             PSLVERR_OUT,          // apb error
    input  wire logic        LOW_POWER_OSC_IN,     // low_power_oscillator tick
    input  wire logic        STOP_MODE_IN,         // chip in stop mode
    input  wire logic        WAIT_MODE_IN,         // chip in wait mode
    input  wire logic        SAFETY_INPUT_IN,      // external safety_input pin
    output logic             SAFETY_OUTPUT_N_OUT,  // safety_output, active low
    output logic             SAFETY_OUTPUT_OE_OUT, // pad driven once enabled
    output logic             IRQ_OUT               // interrupt request
);

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    function automatic logic is_reg(input logic [7:0] addr, input logic [2:0] idx);
        return addr == {3'h0, idx, 2'b00};
    endfunction

    esm_apb_req_t req;
    assign req = {PSEL_IN, PENABLE_IN, PWRITE_IN, PADDR_IN, PWDATA_IN};

    logic       monitor_enable_bit;
    logic       input_polarity_select;
    logic       input_enable_bit;
    logic       interrupt_enable_bit;
    logic       ctrl_done;
    logic [7:0] window_low_compare;
    logic [7:0] window_high_compare;
    logic [7:0] prescale;
    logic       wlo_done;
    logic       whi_done;
    logic       pre_done;
    logic       tripped;
    logic [7:0] count;
    logic       armed;

    wire access    = req.sel && req.en;
    wire take      = access && !PREADY_OUT;
    wire commit    = access && PREADY_OUT;
    wire sel_ctrl  = is_reg(req.addr, `ESM_IDX_CTRL);
    wire sel_serv  = is_reg(req.addr, `ESM_IDX_SERV);
    wire sel_wlo   = is_reg(req.addr, `ESM_IDX_WIN_LO);
    wire sel_whi   = is_reg(req.addr, `ESM_IDX_WIN_HI);
    wire sel_pre   = is_reg(req.addr, `ESM_IDX_PRESCALE);
    wire sel_stat  = is_reg(req.addr, `ESM_IDX_STATUS);
    wire mapped    = sel_ctrl || sel_serv || sel_wlo || sel_whi || sel_pre || sel_stat;

    wire [2:0] once_bits = {req.wdata[`ESM_CTRL_INPUT_EN], req.wdata[`ESM_CTRL_POLARITY],
                            req.wdata[`ESM_CTRL_ENABLE]};
    wire [2:0] once_now  = {input_enable_bit, input_polarity_select, monitor_enable_bit};

    // second write to a write-once field is refused with an error, except a control write that repeats its once bits
    wire once_err  = (sel_ctrl && ctrl_done && once_bits != once_now)
                  || (sel_wlo && wlo_done) || (sel_whi && whi_done)
                  || (sel_pre && pre_done) || sel_stat;
    wire bus_err   = !mapped || (req.write && once_err);
    wire do_wr     = commit && req.write && !PSLVERR_OUT;
    wire wr_ctrl   = do_wr && sel_ctrl;
    wire first_ctl = wr_ctrl && !ctrl_done;
    wire enable_wr = first_ctl && req.wdata[`ESM_CTRL_ENABLE];

    wire [7:0] ctrl_rd = {4'h0, interrupt_enable_bit, input_enable_bit,
                          input_polarity_select, monitor_enable_bit};
    wire [7:0] stat_rd = {6'h00, armed, tripped};
    // refresh register reads as zero; the counter has no read path
    wire [7:0] rd_mux  = sel_ctrl ? ctrl_rd :
                         sel_wlo  ? window_low_compare :
                         sel_whi  ? window_high_compare :
                         sel_pre  ? prescale :
                         sel_stat ? stat_rd : 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // apb slave: ready one cycle into the access phase

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT  <= 32'h0000_0000;
        end else begin
            PREADY_OUT  <= take;
            PSLVERR_OUT <= take && bus_err;
            PRDATA_OUT  <= (take && !req.write && !bus_err) ? {24'h00_0000, rd_mux}
                                                           : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers; any reset loads their reset values, so the monitor returns
    // disabled, and debug mode has no path here at all

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            monitor_enable_bit    <= 1'b0;
            input_polarity_select <= 1'b0;
            input_enable_bit      <= 1'b0;
            interrupt_enable_bit  <= 1'b0;
            ctrl_done             <= 1'b0;
        end else if (wr_ctrl) begin
            interrupt_enable_bit <= req.wdata[`ESM_CTRL_IRQ_EN];
            if (!ctrl_done) begin
                monitor_enable_bit    <= req.wdata[`ESM_CTRL_ENABLE];
                input_polarity_select <= req.wdata[`ESM_CTRL_POLARITY];
                input_enable_bit      <= req.wdata[`ESM_CTRL_INPUT_EN];
                ctrl_done             <= 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            window_low_compare  <= `ESM_WIN_LO_RESET;
            window_high_compare <= `ESM_WIN_HI_RESET;
            prescale            <= `ESM_PRESCALE_RESET;
            wlo_done            <= 1'b0;
            whi_done            <= 1'b0;
            pre_done            <= 1'b0;
        end else begin
            if (do_wr && sel_wlo) begin
                window_low_compare <= req.wdata[7:0];
                wlo_done           <= 1'b1;
            end
            if (do_wr && sel_whi) begin
                window_high_compare <= req.wdata[7:0];
                whi_done            <= 1'b1;
            end
            if (do_wr && sel_pre) begin
                prescale <= req.wdata[7:0];
                pre_done <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // refresh check and counter

    wire stop_mode = STOP_MODE_IN || WAIT_MODE_IN;
    wire serv_wr   = do_wr && sel_serv && monitor_enable_bit;

    esm_refresh_t refresh;

    esm_refresh_chk u_chk (
        .clk_in     (REF_CLK_IN),
        .rst_in     (RST_IN),
        .hold_in    (stop_mode),
        .wr_in      (serv_wr),
        .data_in    (req.wdata[7:0]),
        .result_out (refresh),
        .armed_out  (armed)
    );

    // an interrupt exit just drops stop, so counting resumes where it froze
    wire run_count = monitor_enable_bit && !stop_mode;

    wire win_ok    = (count > window_low_compare) && (count < window_high_compare);
    wire in_assert = monitor_enable_bit && input_enable_bit
                  && (SAFETY_INPUT_IN == input_polarity_select);
    wire good_ref  = monitor_enable_bit && refresh.valid && win_ok && !in_assert;
    wire bad_ref   = refresh.illegal || (refresh.valid && !win_ok);
    wire expired   = count > window_high_compare;
    wire trip      = monitor_enable_bit && (bad_ref || in_assert || expired);

    esm_lp_counter u_cnt (
        .clk_in    (REF_CLK_IN),
        .rst_in    (RST_IN),
        .osc_in    (LOW_POWER_OSC_IN),
        .div_in    (prescale),
        .run_in    (run_count),
        .clear_in  (enable_wr || good_ref),
        .count_out (count)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // safety output: a fault drives it and the interrupt request, no reset leaves the block

    wire next_tripped = enable_wr ? 1'b0 : (tripped || trip);
    wire next_enable  = first_ctl ? req.wdata[`ESM_CTRL_ENABLE] : monitor_enable_bit;
    wire next_irq_en  = wr_ctrl ? req.wdata[`ESM_CTRL_IRQ_EN] : interrupt_enable_bit;

    // output shows asserted through reset, matching the external pull-down
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            tripped              <= 1'b1;
            SAFETY_OUTPUT_N_OUT  <= 1'b0;
            SAFETY_OUTPUT_OE_OUT <= 1'b0;
            IRQ_OUT              <= 1'b0;
        end else begin
            tripped              <= next_tripped;
            SAFETY_OUTPUT_N_OUT  <= !next_tripped;
            SAFETY_OUTPUT_OE_OUT <= next_enable;
            IRQ_OUT              <= next_tripped && next_irq_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);

    // one step per cycle: an enable write in the same cycle may legally clear it
    trip_sticky_a: assert property (tripped && !enable_wr |=> tripped)
        else $error("safety output released without reset");
    enable_clears_a: assert property (enable_wr
                                      |=> SAFETY_OUTPUT_N_OUT && count == 8'h00)
        else $error("enable did not clear counter and output");
    bad_window_a: assert property (monitor_enable_bit && refresh.valid && !win_ok
                                   |=> !SAFETY_OUTPUT_N_OUT)
        else $error("refresh outside window not tripped");
    input_trip_a: assert property (in_assert |=> !SAFETY_OUTPUT_N_OUT)
        else $error("asserted safety input ignored");
    input_ignore_a: assert property ((!monitor_enable_bit || !input_enable_bit) && !tripped
                                     && !trip |=> !tripped)
        else $error("safety input acted while ignored");
    good_refresh_a: assert property (good_ref && !enable_wr |=> count == 8'h00)
        else $error("valid refresh did not clear counter");
    stop_freeze_a: assert property (stop_mode && !enable_wr |=> $stable(count))
        else $error("counter moved in stop mode");
    expiry_trip_a: assert property (monitor_enable_bit && count > window_high_compare
                                    |=> !SAFETY_OUTPUT_N_OUT)
        else $error("timeout did not trip output");
    irq_follow_a: assert property (tripped && interrupt_enable_bit && !wr_ctrl
                                   |=> IRQ_OUT)
        else $error("interrupt request missing");

endmodule

/* File: esm_consts.svh */
`ifndef ESM_CONSTS_SVH
`define ESM_CONSTS_SVH

// register indices; byte address is four times the index
`define ESM_IDX_CTRL        3'h0
`define ESM_IDX_SERV        3'h1
`define ESM_IDX_WIN_LO      3'h2
`define ESM_IDX_WIN_HI      3'h3
`define ESM_IDX_PRESCALE    3'h5
`define ESM_IDX_STATUS      3'h6

// control register field positions
`define ESM_CTRL_ENABLE     0
`define ESM_CTRL_POLARITY   1
`define ESM_CTRL_INPUT_EN   2
`define ESM_CTRL_IRQ_EN     3

// reset values
`define ESM_WIN_LO_RESET    8'h00
`define ESM_WIN_HI_RESET    8'hFF
`define ESM_PRESCALE_RESET  8'h00

// refresh keys and the bus-clock window between them
`define ESM_REFRESH_KEY1    8'hB4
`define ESM_REFRESH_KEY2    8'h2C
`define ESM_SERVICE_CYCLES  4'hF

`endif

/* File: esm_pkg.sv */
package esm_pkg;

    typedef struct packed {
        logic        sel;
        logic        en;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } esm_apb_req_t;

    typedef struct packed {
        logic valid;
        logic illegal;
    } esm_refresh_t;

    typedef enum logic [1:0] {
        ESM_CHK_IDLE  = 2'b01,
        ESM_CHK_ARMED = 2'b10
    } esm_chk_state_t;

endpackage

/* File: esm_refresh_chk.sv */
`timescale 1ns/10ps
`include "esm_consts.svh"

module esm_refresh_chk
    import esm_pkg::*;
(
    input  wire logic         clk_in,     // bus clock
    input  wire logic         rst_in,     // async reset, active high
    input  wire logic         hold_in,    // stop or wait mode
    input  wire logic         wr_in,      // refresh register write, one cycle
    input  wire logic [7:0]   data_in,    // written byte
    output esm_refresh_t      result_out, // registered outcome pulses
    output logic              armed_out   // first key accepted
);

    esm_chk_state_t state;
    esm_chk_state_t next_state;
    logic [3:0]     cnt;
    logic [3:0]     next_cnt;
    esm_refresh_t   next_result;

    wire key1_hit = (data_in == `ESM_REFRESH_KEY1);
    wire key2_hit = (data_in == `ESM_REFRESH_KEY2);
    wire last_cyc = (cnt == `ESM_SERVICE_CYCLES - 4'h1);

    // while held nothing moves, so the byte timer resumes after stop exit
    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_result = '0;
        case (state)
            ESM_CHK_IDLE: begin
                if (wr_in && !hold_in) begin
                    if (key1_hit) begin
                        next_state = ESM_CHK_ARMED;
                        next_cnt   = 4'h0;
                    end else begin
                        next_result.illegal = 1'b1;
                    end
                end
            end
            ESM_CHK_ARMED: begin
                if (!hold_in) begin
                    if (wr_in) begin
                        next_state          = ESM_CHK_IDLE;
                        next_result.valid   = key2_hit;
                        next_result.illegal = !key2_hit;
                    end else if (last_cyc) begin
                        next_state          = ESM_CHK_IDLE;
                        next_result.illegal = 1'b1;
                    end else begin
                        next_cnt = cnt + 4'h1;
                    end
                end
            end
            default: begin
                next_state = ESM_CHK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state      <= ESM_CHK_IDLE;
            cnt        <= 4'h0;
            result_out <= '0;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            result_out <= next_result;
        end
    end

    assign armed_out = (state == ESM_CHK_ARMED);

    ////////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence key1_taken;
        state == ESM_CHK_IDLE && wr_in && !hold_in && key1_hit;
    endsequence

    sequence key2_taken;
        wr_in && !hold_in && key2_hit;
    endsequence

    property quick_pair;
        key1_taken ##1 (!wr_in && !hold_in) [*3] ##1 key2_taken |=> result_out.valid;
    endproperty

    key_pair_a: assert property (quick_pair)
        else $error("refresh pair inside window not accepted");
    late_key_a: assert property (armed_out && last_cyc && !wr_in && !hold_in
                                 |=> result_out.illegal && !armed_out)
        else $error("late second key not flagged");
    hold_keep_a: assert property (hold_in |=> $stable(cnt) && $stable(state))
        else $error("checker moved while held");

endmodule

/* File: esm_lp_counter.sv */
`timescale 1ns/10ps
`include "esm_consts.svh"

module esm_lp_counter (
    input  wire logic       clk_in,    // bus clock
    input  wire logic       rst_in,    // async reset, active high
    input  wire logic       osc_in,    // low-power oscillator tick, one cycle
    input  wire logic [7:0] div_in,    // prescaler divide-by minus one
    input  wire logic       run_in,    // count enable
    input  wire logic       clear_in,  // clear counter and prescaler
    output logic      [7:0] count_out  // timeout count
);

    logic [7:0] pre;

    wire tick     = osc_in && run_in && (pre == div_in);
    wire saturate = (count_out == 8'hFF);

    // saturating so an open high compare of FF never wraps into the window
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre       <= 8'h00;
            count_out <= 8'h00;
        end else if (clear_in) begin
            pre       <= 8'h00;
            count_out <= 8'h00;
        end else if (osc_in && run_in) begin
            pre <= tick ? 8'h00 : pre + 8'h01;
            if (tick && !saturate) begin
                count_out <= count_out + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    count_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
                                   !run_in && !clear_in |=> $stable(count_out))
        else $error("counter moved while not running");

endmodule

/* File: esm_safety_circuit.sv */
`timescale 1ns/10ps
////////////////////////////////////////
module esm_safety_circuit (
    input  wire logic fault_in, // external fault present
    input  wire logic pol_in,   // level that means asserted
    output logic      pin_out   // safety_input pin level
);
    // the pin always shows a defined level, never floats
    assign pin_out = fault_in ? pol_in : ~pol_in;
endmodule

/* File: external_safety_watchdog_test.sv */
`timescale 1ns/10ps
`include "esm_consts.svh"
module external_safety_watchdog_test;
    localparam logic [7:0]  A_CTRL = {3'h0, `ESM_IDX_CTRL, 2'h0};
    localparam logic [7:0]  A_SERV = {3'h0, `ESM_IDX_SERV, 2'h0};
    localparam logic [7:0]  A_WLO  = {3'h0, `ESM_IDX_WIN_LO, 2'h0};
    localparam logic [7:0]  A_WHI  = {3'h0, `ESM_IDX_WIN_HI, 2'h0};
    localparam logic [7:0]  A_PRE  = {3'h0, `ESM_IDX_PRESCALE, 2'h0};
    localparam logic [7:0]  A_STAT = {3'h0, `ESM_IDX_STATUS, 2'h0};
    localparam logic [7:0]  K1     = `ESM_REFRESH_KEY1;
    localparam logic [7:0]  K2     = `ESM_REFRESH_KEY2;
    localparam logic [31:0] ALL    = 32'hFFFFFFFF;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic        osc = 1'b0;
    logic        stop = 1'b0;
    logic        wt = 1'b0;
    logic        fault = 1'b0;
    logic        pol = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, pin, out_n, oe, irq;
    logic [31:0] seed = 32'h0000000E;
    int          m_cnt, m_pre, m_div, m_wlo, m_whi, m_en, m_in_en, m_irq, m_trip, m_hold;
    int          fail_count = 0;
    int          n_compared = 0;
    always #2 clk = ~clk;
    esm_top dut (.REF_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .LOW_POWER_OSC_IN(osc),
        .STOP_MODE_IN(stop), .WAIT_MODE_IN(wt), .SAFETY_INPUT_IN(pin),
        .SAFETY_OUTPUT_N_OUT(out_n), .SAFETY_OUTPUT_OE_OUT(oe), .IRQ_OUT(irq));
    esm_safety_circuit partner (.fault_in(fault), .pol_in(pol), .pin_out(pin));
    ////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic bad(input string s);
        fail_count++;
        $display("MISMATCH t=%0t %s", $time, s);
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) bad($sformatf("bus got %h exp %h", got, exp));
    endtask
    task automatic chk_pins();
        logic [2:0] x;
        x = {m_en != 0 && m_trip == 0, m_en != 0, m_trip != 0 && m_irq != 0};
        repeat (3) @(posedge clk);
        n_compared++;
        if ({out_n, oe, irq} !== x) bad($sformatf("pins %b exp %b", {out_n, oe, irq}, x));
    endtask
    // request held from setup until ready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            bad("no ready");
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic e);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, {24'h000000, d}, rd, err);
        chk_reg({31'h0, err}, {31'h0, e});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                       input logic e);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h00000000, rd, err);
        chk_reg(rd & m, x);
        chk_reg({31'h0, err}, {31'h0, e});
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            osc <= 1'b1;
            @(posedge clk);
            osc <= 1'b0;
            if (m_en != 0 && m_hold == 0) m_pre++;
            if (m_pre > m_div) begin
                m_pre = 0;
                m_cnt = (m_cnt < 255) ? m_cnt + 1 : 255;
                if (m_cnt > m_whi) m_trip = 1;
            end
        end
    endtask
    task automatic judge(input logic ok);
        if (ok && m_cnt > m_wlo && m_cnt < m_whi && !(m_in_en != 0 && fault)) m_cnt = 0;
        else m_trip = 1;
    endtask
    // the bytes go out gap edges apart, back to back at gap 0 as with interrupts masked
    task automatic serv(input logic [7:0] b1, input logic [7:0] b2, input int gap);
        wr(A_SERV, b1, 1'b0);
        repeat (gap) @(posedge clk);
        wr(A_SERV, b2, 1'b0);
        // commits of two back-to-back writes land four edges apart
        if (m_en != 0 && m_hold == 0)
            judge(b1 == K1 && b2 == K2 && gap + 4 <= `ESM_SERVICE_CYCLES);
    endtask
    // every scenario starts from a fresh reset since a trip only clears on the first enabling control write after reset
    task automatic cfg(input int lo, input int hi, input int dv, input logic [7:0] c);
        @(posedge clk);
        rst <= 1'b1;
        stop <= 1'b0;
        wt <= 1'b0;
        fault <= 1'b0;
        pol <= c[1];
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        m_cnt = 0;
        m_pre = 0;
        m_trip = 0;
        m_hold = 0;
        m_wlo = lo;
        m_whi = hi;
        m_div = dv;
        m_en = c[0];
        m_in_en = c[2];
        m_irq = c[3];
        wr(A_WLO, lo[7:0], 1'b0);
        wr(A_WHI, hi[7:0], 1'b0);
        wr(A_PRE, dv[7:0], 1'b0);
        wr(A_CTRL, c, 1'b0);
    endtask
    ////////////////////////////////////////
    initial begin
        #400000;
        bad("timeout");
        give_verdict();
    end
    initial begin
        int         j;
        int         lo;
        logic [7:0] b;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(A_CTRL, ALL, 32'h00000000, 1'b0);
        rdc(A_WHI, ALL, 32'h000000FF, 1'b0);
        rdc(A_PRE, ALL, 32'h00000000, 1'b0);
        rdc(A_SERV, ALL, 32'h00000000, 1'b0);
        rdc(8'h1C, ALL, 32'h00000000, 1'b1);
        wr(A_SERV, K1, 1'b0);
        rdc(A_STAT, 32'h00000003, 32'h00000001, 1'b0);
        chk_pins();
        cfg(2, 32, 0, 8'h09);
        chk_pins();
        wr(A_WLO, 8'h05, 1'b1);
        wr(A_STAT, 8'h00, 1'b1);
        rdc(A_CTRL, ALL, 32'h00000009, 1'b0);
        $display("test setup done");
        for (j = 0; j < 4; j++) begin
            lo = 1 + int'(xs() % 8);
            cfg(lo, lo + 6, 0, 8'h09);
            tick(j == 0 ? lo : j == 1 ? lo + 1 : j == 2 ? lo + 5 : lo + 6);
            serv(K1, K2, 0);
            chk_pins();
        end
        $display("test window done");
        cfg(0, 4, 1, 8'h01);
        tick(8);
        chk_pins();
        tick(2);
        chk_pins();
        serv(K1, K2, 0);
        repeat (50) @(posedge clk);
        chk_pins();
        $display("test timeout done");
        for (j = 0; j < 4; j++) begin
            b = 8'(xs());
            if (b == K1 || b == K2) b = 8'h5A;
            cfg(0, 254, 0, 8'h09);
            tick(3);
            serv(j == 0 ? b : K1, j == 1 ? b : K2, j == 2 ? 12 : j == 3 ? 11 : 0);
            chk_pins();
        end
        $display("test keys done");
        for (j = 0; j < 4; j++) begin
            cfg(0, 254, 0, {5'h00, j[1], j[0], 1'b1});
            fault <= 1'b1;
            m_trip = m_in_en;
            chk_pins();
        end
        $display("test input done");
        for (j = 0; j < 2; j++) begin
            cfg(2, 16, 0, 8'h09);
            tick(4);
            stop <= (j == 0);
            wt <= (j == 1);
            m_hold = 1;
            tick(40);
            serv(8'h00, 8'h00, 0);
            chk_pins();
            stop <= 1'b0;
            wt <= 1'b0;
            m_hold = 0;
            tick(12);
            chk_pins();
            tick(1);
            chk_pins();
        end
        $display("test low power done");
        cfg(2, 16, 0, 8'h09);
        tick(5);
        wr(A_SERV, K1, 1'b0);
        stop <= 1'b1;
        rdc(A_STAT, 32'h00000003, 32'h00000002, 1'b0);
        repeat (40) @(posedge clk);
        stop <= 1'b0;
        wr(A_SERV, K2, 1'b0);
        judge(1'b1);
        tick(16);
        chk_pins();
        $display("test split refresh done");
        give_verdict();
    end
endmodule
